// *** hw/sync_serial_spi_port.sv ***
`default_nettype none
module sync_serial_spi_port
    import spi_port_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // ahb-lite slave
    input  wire logic         hsel_i,
    input  wire logic [31:0]  haddr_i,
    input  wire logic [1:0]   htrans_i,
    input  wire logic         hwrite_i,
    input  wire logic [2:0]   hsize_i,
    input  wire logic         hready_i,
    input  wire logic [31:0]  hwdata_i,
    output logic      [31:0]  hrdata_o,
    output logic              hreadyout_o,
    output logic              hresp_o,
    // serial pins, inputs
    input  wire logic         sck_i,
    input  wire logic         sdi_i,
    input  wire logic         ss_n_i,
    input  wire logic         timer_tick_i,
    // serial pins, outputs
    output pin_out_s          pins_o,
    output logic              serial_irq_flag_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cfg_s        cfg_q;                        // control bits
    logic [7:0]  reload_q;                     // baud_reload_reg
    logic [7:0]  sr_q;                         // serial_shift_reg
    logic [7:0]  buf_q;                        // serial_data_buffer
    logic [2:0]  cnt_q;                        // bits taken in this byte
    logic [4:0]  hb_q;                         // host half bits done
    host_state_e st_q;                         // host sequencer
    logic        bf_q;                         // buffer_full_flag
    logic        write_collision_flag_q;                       // write_collision_flag
    logic        sck_q;                        // last seen clock pin
    logic [7:0]  addr_q;                       // bus data phase address
    logic        wr_q;                         // bus write data phase
    logic        rd_q;                         // bus read wait cycle
    logic [31:0] rmux;                         // read data select
    logic        tick;                         // host half period tick

    // ------------------------------------------------------------
    // decode and events
    // ------------------------------------------------------------
    logic       is_host, is_cli, sel_ok, ss_rst, cli_act;
    logic       lead_c, trail_c, samp, outv, done_ev, busy;
    logic       wr_buf, load, coll, start, acc, run;
    logic [4:0] hb_t;
    logic [7:0] shifted;

    // host codes and client codes; others leave the port inert
    assign is_host = cfg_q.en && (cfg_q.mode[3:2] == 2'b00
                                  || cfg_q.mode == MODE_RELOAD);
    assign is_cli  = cfg_q.en && (cfg_q.mode == MODE_CLI_SS
                                  || cfg_q.mode == MODE_CLI);
    assign sel_ok  = (cfg_q.mode == MODE_CLI) || !ss_n_i;
    assign ss_rst  = (cfg_q.mode == MODE_CLI_SS) && ss_n_i;
    assign cli_act = is_cli && sel_ok;
    assign run     = (st_q == ST_RUN);
    assign hb_t    = hb_q + 5'h01;

    // client edges, leading leaves the idle level
    assign lead_c  = (sck_i != cfg_q.clock_idle_level) && (sck_q == cfg_q.clock_idle_level);
    assign trail_c = (sck_i == cfg_q.clock_idle_level) && (sck_q != cfg_q.clock_idle_level);

    // host: odd half bits are leading edges; end sampling waits one half
    always_comb begin
        if (is_host) begin
            samp = run && tick && (hb_t[0] == (cfg_q.cke ^ cfg_q.input_sample_phase))
                   && (cfg_q.input_sample_phase ? hb_t >= 5'h02 : hb_t <= HB_EDGE_MAX);
            outv = run && tick && (hb_t[0] == !cfg_q.cke)
                   && (hb_t <= HB_OUT_MAX);
        end else begin
            samp = cli_act && (cfg_q.cke ? lead_c : trail_c);
            outv = cli_act && (cfg_q.cke ? trail_c : lead_c);
        end
    end

    assign shifted = {sr_q[6:0], sdi_i};
    assign done_ev = samp && (cnt_q == BIT_LAST);
    assign busy    = is_host ? run : (cnt_q != 3'h0);
    assign wr_buf  = wr_q && (addr_q == OFS_DATA);
    // a pending collision blocks writes until software clears it
    assign load    = wr_buf && !busy && !write_collision_flag_q;
    assign coll    = wr_buf && !load;
    assign start   = load && is_host;

    // ------------------------------------------------------------
    // host clock divider
    // ------------------------------------------------------------
    spi_rate_gen #(
        .CW       (10)
    ) u_rate (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .run_i    (run),
        .mode_i   (cfg_q.mode),
        .reload_i (reload_q),
        .timer_i  (timer_tick_i),
        .tick_o   (tick)
    );

    // ------------------------------------------------------------
    // host sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= ST_IDLE;
            hb_q <= '0;
        end else if (!is_host) begin
            st_q <= ST_IDLE;
            hb_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    hb_q <= '0;
                    if (start) begin
                        st_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        hb_q <= hb_t;
                        // closing half keeps the last bit whole
                        if (hb_t == HB_LAST) begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bit counter and shift register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
        end else if (!cfg_q.en || ss_rst || start) begin
            cnt_q <= '0;
        end else if (samp) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sr_q <= '0;
        end else if (load) begin
            sr_q <= hwdata_i[7:0];
        end else if (samp) begin
            sr_q <= shifted;
        end
    end

    // ------------------------------------------------------------
    // receive buffer and its flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_q <= '0;
        end else if (done_ev) begin
            buf_q <= shifted;
        end else if (load) begin
            buf_q <= hwdata_i[7:0];
        end
    end

    // set wins over the read that clears
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bf_q <= 1'b0;
        end else if (done_ev) begin
            bf_q <= 1'b1;
        end else if (rd_q && addr_q == OFS_DATA) begin
            bf_q <= 1'b0;
        end
    end

    // buffer reads leave it alone; only a one written clears it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_irq_flag_o <= 1'b0;
        end else if (done_ev) begin
            serial_irq_flag_o <= 1'b1;
        end else if (wr_q && addr_q == OFS_IRQ && hwdata_i[IRQ_BIT]) begin
            serial_irq_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            write_collision_flag_q <= 1'b0;
        end else if (coll) begin
            write_collision_flag_q <= 1'b1;
        end else if (wr_q && addr_q == OFS_CTRL1 && !hwdata_i[C1_WRITE_COLLISION_FLAG]) begin
            write_collision_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_o <= PINS_RST;
            sck_q  <= 1'b0;
        end else begin
            sck_q         <= sck_i;
            pins_o.sck_oe <= is_host;
            pins_o.sdo_oe <= is_host || cli_act;
            if (!run) begin
                pins_o.sck <= cfg_q.clock_idle_level;
            end else if (tick && hb_t <= HB_EDGE_MAX) begin
                pins_o.sck <= !pins_o.sck;
            end
            if (load) begin
                pins_o.sdo <= hwdata_i[7];
            end else if (outv) begin
                pins_o.sdo <= samp ? sr_q[6] : sr_q[7];
            end
        end
    end

    // ------------------------------------------------------------
    // ahb-lite slave: writes zero wait, reads one wait state
    // ------------------------------------------------------------
    assign acc     = hsel_i && hready_i && htrans_i[1];
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q <= OFS_NONE;
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
        end else begin
            // high address bits must be zero, else the access is unmapped
            addr_q <= (haddr_i[31:5] == 27'h0 && haddr_i[1:0] == 2'b00)
                      ? haddr_i[7:0] : OFS_NONE;
            wr_q   <= acc && hwrite_i;
            rd_q   <= acc && !hwrite_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q    <= CFG_RST;
            reload_q <= '0;
        end else if (wr_q) begin
            case (addr_q)
                OFS_CTRL1: begin
                    cfg_q.en   <= hwdata_i[C1_EN];
                    cfg_q.clock_idle_level  <= hwdata_i[C1_CKP];
                    cfg_q.mode <= hwdata_i[3:0];
                end
                OFS_STATUS: begin
                    cfg_q.input_sample_phase  <= hwdata_i[ST_SMP];
                    cfg_q.cke  <= hwdata_i[ST_CKE];
                end
                OFS_RELOAD: reload_q <= hwdata_i[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rmux = '0;
        case (addr_q)
            OFS_STATUS: rmux[7:0] = {cfg_q.input_sample_phase, cfg_q.cke, 5'h00, bf_q};
            OFS_CTRL1:  rmux[7:0] = {write_collision_flag_q, 1'b0, cfg_q.en, cfg_q.clock_idle_level, cfg_q.mode};
            OFS_DATA:   rmux[7:0] = buf_q;
            OFS_RELOAD: rmux[7:0] = reload_q;
            OFS_IRQ:    rmux[0]   = serial_irq_flag_o;
            default:    rmux      = '0;
        endcase
    end

    // wait cycle lets a write just before a read land first
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_o    <= '0;
            hreadyout_o <= 1'b1;
        end else begin
            hreadyout_o <= !(acc && !hwrite_i);
            if (rd_q) begin
                hrdata_o <= rmux;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_MSB_FIRST: assert property (load |=> pins_o.sdo == sr_q[7])
        else $error("sdo does not show the loaded msb");
    AST_EDGES_APART: assert property (!cfg_q.input_sample_phase |-> !(samp && outv))
        else $error("sample and drive on one edge");
    AST_IDLE_LEVEL: assert property (is_host && !run ##1 is_host && !run
                                     |-> pins_o.sck == cfg_q.clock_idle_level)
        else $error("host clock not at idle level");
    AST_EIGHT_BITS: assert property (done_ev |=> cnt_q == 3'h0 && buf_q == $past(shifted))
        else $error("byte not complete after eight bits");
    AST_DESELECT: assert property (is_cli && !sel_ok |=> !pins_o.sdo_oe)
        else $error("unselected client drives data");
    AST_SS_CLEAR: assert property (is_cli && ss_rst |=> cnt_q == 3'h0)
        else $error("select high left bit count");
    AST_COPY_FLAGS: assert property (done_ev |=> bf_q && serial_irq_flag_o)
        else $error("received byte did not set flags");
    AST_BF_READ: assert property (rd_q && addr_q == OFS_DATA && !done_ev |=> !bf_q)
        else $error("buffer read left full flag");
    AST_COLLIDE: assert property (wr_buf && busy |=> write_collision_flag_q && $stable(buf_q))
        else $error("collision not flagged or write taken");
    AST_STATUS_RO: assert property (wr_q && addr_q == OFS_STATUS && !done_ev
                                    && !rd_q |=> $stable(bf_q))
        else $error("status low bits written");
    AST_DISABLED: assert property (!cfg_q.en |=> !run && cnt_q == 3'h0
                                   && !pins_o.sdo_oe && !pins_o.sck_oe)
        else $error("port active while disabled");
    // slowest reload half period is 512 cycles, so the first tick lands within 600
    AST_HOST_GO: assert property (start |=> run ##[1:600] (hb_q != 5'h00))
        else $error("host transfer did not start");
    AST_IRQ_HOLD: assert property (serial_irq_flag_o && !(wr_q && addr_q == OFS_IRQ)
                                   |=> serial_irq_flag_o)
        else $error("irq flag dropped by itself");
    AST_DIV4: assert property (run && cfg_q.mode == MODE_DIV4 && tick && hb_t < HB_LAST
                               |-> ##2 tick)
        else $error("clk/4 half period not two cycles");

    COV_HOST_BYTE: cover property (is_host && done_ev);
    COV_CLI_BYTE: cover property (cli_act && done_ev);
    COV_COLLIDE: cover property (coll);
    COV_SS_ABORT: cover property (ss_rst && cnt_q != 3'h0);

endmodule : sync_serial_spi_port
`default_nettype wire

// *** hw/spi_port_pkg.sv ***
`default_nettype none
package spi_port_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the word bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS  = 8'h00; // serial_status_reg
    localparam logic [7:0] OFS_CTRL1   = 8'h04; // serial_control_one
    localparam logic [7:0] OFS_DATA    = 8'h08; // serial_data_buffer
    localparam logic [7:0] OFS_RELOAD  = 8'h0c; // baud_reload_reg
    localparam logic [7:0] OFS_IRQ     = 8'h10; // serial_irq_flag, write one to clear
    localparam logic [7:0] OFS_NONE    = 8'hff; // marks an unmapped access

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ST_SMP   = 7;               // input_sample_phase
    localparam int ST_CKE   = 6;               // output clock edge select
    localparam int ST_BF    = 0;               // buffer_full_flag
    localparam int C1_WRITE_COLLISION_FLAG  = 7;               // write_collision_flag
    localparam int C1_EN    = 5;               // port_enable_bit
    localparam int C1_CKP   = 4;               // clock_idle_level
    localparam int IRQ_BIT  = 0;               // serial_irq_flag

    // ------------------------------------------------------------
    // port_mode_select codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_DIV4   = 4'h0; // host, clk/4
    localparam logic [3:0] MODE_DIV16  = 4'h1; // host, clk/16
    localparam logic [3:0] MODE_DIV64  = 4'h2; // host, clk/64
    localparam logic [3:0] MODE_TMR    = 4'h3; // host, timer output / 2
    localparam logic [3:0] MODE_CLI_SS = 4'h4; // client, select pin used
    localparam logic [3:0] MODE_CLI    = 4'h5; // client, select pin ignored
    localparam logic [3:0] MODE_RELOAD = 4'ha; // host, clk/(4*(reload+1))

    // ------------------------------------------------------------
    // timing counts: clk cycles per half serial clock period, then half bit and bit numbers
    // ------------------------------------------------------------
    localparam logic [9:0] HALF_DIV4   = 10'h002;
    localparam logic [9:0] HALF_DIV16  = 10'h008;
    localparam logic [9:0] HALF_DIV64  = 10'h020;
    localparam logic [9:0] HALF_STEP   = 10'h002; // per reload step
    localparam logic [4:0] HB_EDGE_MAX = 5'h10;   // last half bit with a clock edge
    localparam logic [4:0] HB_OUT_MAX  = 5'h0f;   // last half bit that drives data
    localparam logic [4:0] HB_LAST     = 5'h11;   // closing half bit of a byte
    localparam logic [2:0] BIT_LAST    = 3'h7;    // eighth bit of a byte

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic { ST_IDLE = 1'b0, ST_RUN = 1'b1 } host_state_e;

    typedef struct packed {
        logic       en;   // port_enable_bit
        logic       clock_idle_level;  // clock_idle_level
        logic [3:0] mode; // port_mode_select
        logic       input_sample_phase;  // input_sample_phase
        logic       cke;  // output clock edge select
    } cfg_s;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
    } pin_out_s;

    localparam cfg_s     CFG_RST  = '0;
    localparam pin_out_s PINS_RST = '0;

endpackage : spi_port_pkg
`default_nettype wire

// *** hw/spi_rate_gen.sv ***
`default_nettype none
module spi_rate_gen
    import spi_port_pkg::*;
#(
    parameter int CW = 10                      // half period counter width
)(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // control
    input  wire logic         run_i,           // host byte in progress
    input  wire logic [3:0]   mode_i,          // port_mode_select
    input  wire logic [7:0]   reload_i,        // baud_reload_reg
    input  wire logic         timer_i,         // timer output pulse
    // half period tick
    output logic              tick_o
);

    // ------------------------------------------------------------
    // half period length per mode
    // ------------------------------------------------------------
    logic [CW-1:0] half;                       // clk cycles per half period
    logic [CW-1:0] cnt_q;                      // cycles into this half

    always_comb begin
        case (mode_i)
            MODE_DIV16:  half = CW'(HALF_DIV16);
            MODE_DIV64:  half = CW'(HALF_DIV64);
            // two clk per step, so the full period is 4*(reload+1)
            MODE_RELOAD: half = CW'(HALF_STEP * ({2'b00, reload_i} + 10'h001));
            default:     half = CW'(HALF_DIV4);
        endcase
    end

    // ------------------------------------------------------------
    // counter; restarts with each byte so the first half is whole
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (mode_i == MODE_TMR) begin
            // each timer pulse is half a serial clock period
            tick_o <= timer_i;
        end else if (cnt_q == half - CW'(1)) begin
            cnt_q  <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + CW'(1);
            tick_o <= 1'b0;
        end
    end

endmodule : spi_rate_gen
`default_nettype wire

// *** verif/spi_client_model.sv ***
`default_nettype none
module spi_client_model (
    // serial side
    input  wire logic       sck_i,
    input  wire logic       sdo_i,
    input  wire logic       sel_n_i,
    // byte to send, shifter seen by the bench
    input  wire logic [7:0] tx_i,
    output logic            sdi_o,
    output logic [7:0]      rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sdi_o = 1'b0;
    // load on select, msb valid before the first edge
    always @(negedge sel_n_i) begin
        rx_o = tx_i;
        sdi_o = tx_i[7];
    end
    // leading edge samples, lsb shifts in
    always @(posedge sck_i) if (!sel_n_i) rx_o = {rx_o[6:0], sdo_i};
    // trailing edge drives the next msb
    always @(negedge sck_i) if (!sel_n_i) sdi_o = rx_o[7];
    // released line has no pull: show the inverse of the last bit
    always @(posedge sel_n_i) sdi_o = ~sdi_o;
endmodule : spi_client_model
`default_nettype wire

// *** verif/sync_serial_spi_port_test.sv ***
`default_nettype none
module sync_serial_spi_port_test import spi_port_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // bench signals
    // ------------------------------------------------------------
    logic        clk_i = 0, resetn_i = 0, hwrite = 0, sel_n = 1, sdi, hready, hresp, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0]  htrans = 0;
    logic [7:0]  tx = 0, rx, b;
    pin_out_s    pins;
    int          n_fail = 0, samples_checked = 0, cyc = 0, seed = 32'h55c633cd;
    always #2.5 clk_i = ~clk_i;
    sync_serial_spi_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .sck_i(pins.sck), .sdi_i(sdi), .ss_n_i(sel_n),
        .timer_tick_i(1'b0), .pins_o(pins), .serial_irq_flag_o(irq));
    spi_client_model peer (.sck_i(pins.sck), .sdo_i(pins.sdo), .sel_n_i(sel_n),
        .tx_i(tx), .sdi_o(sdi), .rx_o(rx));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // hang guard, a few thousand cycles cover every test
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        xfer(0, OFS_STATUS, 0, r); chk("status_rst", 0, r);
        xfer(1, OFS_STATUS, 32'hff, r);
        xfer(0, OFS_STATUS, 0, r); chk("status_rw", 32'hc0, r);
        xfer(0, 8'h20, 0, r); chk("unmapped", 0, r);
        chk("hresp", 0, hresp);
        // sample leading, drive trailing; host at clk/4
        xfer(1, OFS_STATUS, 32'h40, r);
        xfer(1, OFS_CTRL1, 32'h20, r);
        repeat (4) begin
            b = $random(seed);
            tx <= $random(seed);
            @(posedge clk_i);
            sel_n <= 1'b0;
            xfer(1, OFS_DATA, b, r);
            xfer(1, OFS_DATA, ~b, r);
            xfer(0, OFS_CTRL1, 0, r); chk("write_collision_flag", 1, r[7]);
            for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk_i);
            chk("irq", 1, irq);
            xfer(0, OFS_STATUS, 0, r); chk("bf_set", 1, r[0]);
            xfer(0, OFS_DATA, 0, r); chk("rx_byte", tx, r);
            chk("tx_byte", b, rx);
            xfer(0, OFS_STATUS, 0, r); chk("bf_clr", 0, r[0]);
            chk("irq_hold", 1, irq);
            sel_n <= 1'b1;
            xfer(1, OFS_IRQ, 1, r);
            xfer(1, OFS_CTRL1, 32'h20, r);
            $display("byte exchange done");
        end
        // client with select pin, unselected then selected
        xfer(1, OFS_CTRL1, 32'h24, r);
        repeat (2) @(posedge clk_i);
        chk("sdo_oe_off", 0, pins.sdo_oe);
        sel_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("sdo_oe_on", 1, pins.sdo_oe);
        sel_n <= 1'b1;
        xfer(1, OFS_CTRL1, 0, r);
        repeat (2) @(posedge clk_i);
        chk("disabled", 0, pins.sdo_oe);
        $display("client select done");
        report_and_stop();
    end
endmodule : sync_serial_spi_port_test
`default_nettype wire
